/* File: psd_host.sv */
`timescale 1ns/1ns
module psd_host (
    input  wire logic         i_clk,
    input  wire logic [15:0]  i_rdata,
    output psd_pkg::psd_req_s o_req
);
    initial o_req = '0;
    // One-cycle command; released lines show inverted residue, not stale data
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q);
        @(negedge i_clk);
        o_req = '{w, !w, c, d};
        @(negedge i_clk);
        q = i_rdata;
        o_req = '{1'b0, 1'b0, ~c, ~d};
    endtask : xfer
endmodule : psd_host

/* File: psd_pkg.sv */
package psd_pkg;

    // Command codes on page 0
    localparam logic [7:0] CMD_CURRENT_SENSE_INPUT_TWELVE    = 8'hDB;
    localparam logic [7:0] CMD_CS13    = 8'hDC;
    localparam logic [7:0] CMD_CS14    = 8'hDD;
    localparam logic [7:0] CMD_CS15    = 8'hDE;
    localparam logic [7:0] CMD_CS16    = 8'hDF;
    localparam logic [7:0] CMD_ADDR    = 8'hE4;
    localparam logic [7:0] CMD_CONFIG  = 8'hE5;
    localparam logic [7:0] CMD_RFLT_LO = 8'hE7;
    localparam logic [7:0] CMD_RFLT_HI = 8'hE8;
    localparam logic [7:0] CMD_SKIP_R1 = 8'hE9;

    // Field widths and positions
    localparam int          CS_W        = 10;
    localparam int          CFG_W       = 4;
    localparam int          ADDR_W      = 8;
    localparam int          RFLT_HI_W   = 4;
    localparam int          NPH         = 16;
    localparam int          NCS         = 5;
    localparam logic [15:0] RFLT_HI_MSK = 16'h000F;
    localparam logic [15:0] SKIP_RST    = 16'h0000;
    localparam logic [15:0] RFLT_RST    = 16'h0000;

    // Filter averaging shift (samples weighted 1/2^k)
    localparam int          AVG_SHIFT   = 3;

    // Register access request from the command decoder
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  cmd;
        logic [15:0] wdata;
    } psd_req_s;

endpackage : psd_pkg

/* File: psd_regs.sv */
`timescale 1ns/1ns

module psd_regs #(
    parameter int NPH    = psd_pkg::NPH,
    parameter int PERIOD = 100
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_b,
    input  wire psd_pkg::psd_req_s        i_req,
    output logic [15:0]                   o_rdata,
    output logic                          o_rvalid,
    input  wire logic                     i_cs_valid,
    input  wire logic [psd_pkg::NCS*psd_pkg::CS_W-1:0] i_cs_code,
    input  wire logic [7:0]               i_bus_addr,
    input  wire logic [3:0]               i_config_num,
    input  wire logic [19:0]              i_rfault_set,
    input  wire logic [NPH-1:0]           i_pwm_raw,
    output logic [NPH-1:0]                o_pwm,
    output logic [NPH-1:0]                o_pwm_oe,
    output logic [NPH-1:0]                o_phase_tick
);

    ////////////////////////////////////////////////////////////////
    // Overview
    //
    // Three jobs share this block:
    //  - five filtered current-sense readbacks and two live level readbacks
    //  - sticky redundancy fault flags for phases 1 to 20
    //  - a debug mask that parks rail-one phases and re-spaces the rest
    //
    // Host access is one command per cycle; a read answers one cycle later
    // and the answer word holds until the next read. Writes land the
    // following cycle, except the mask, which waits for a period wrap.
    //
    // The averages start from zero after reset, so the first readbacks
    // climb towards the input code; software should let a few
    // tens of conversions pass before trusting them.
    //
    // After reset every phase is enabled and no fault is flagged, so a
    // part that comes up without host traffic behaves as a plain
    // interleaved rail. The mask only ever removes phases, it never
    // adds one that the modulator does not drive.

    ////////////////////////////////////////////////////////////////
    // Current-sense averaging

    // Filter state, one accumulator per sense channel
    logic [psd_pkg::CS_W+psd_pkg::AVG_SHIFT-1:0] avg_reg [psd_pkg::NCS];

    // Fault flags and mask words
    logic [15:0]    rflt_lo_reg;
    logic [3:0]     rflt_hi_reg;
    logic [15:0]    skip_reg;
    logic [15:0]    skip_live_reg;

    // Read path
    logic [15:0]    rdata_next;

    // Interleave engine
    logic [15:0]    cnt_reg;
    logic           at_wrap;
    logic [4:0]     nact;
    logic [15:0]    slot;
    logic [NPH-1:0] mask_live;

    function automatic logic [15:0] zext_cs(
        input logic [psd_pkg::CS_W+psd_pkg::AVG_SHIFT-1:0] acc
    );
        zext_cs = {6'h00, acc[psd_pkg::CS_W+psd_pkg::AVG_SHIFT-1:psd_pkg::AVG_SHIFT]};
    endfunction : zext_cs

    // exponential average
    // Accumulator holds value scaled by 2^k, so the filter keeps full precision
    // Settling takes a few tens of conversions; a step shows up slowly
    // Accumulator width leaves room for a full-scale code without wrap
    // Codes are only taken on a valid pulse, so idle gaps hold the average
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < psd_pkg::NCS; i++) begin
                avg_reg[i] <= '0;
            end
        end else if (i_cs_valid) begin
            for (int i = 0; i < psd_pkg::NCS; i++) begin
                avg_reg[i] <= avg_reg[i] - (avg_reg[i] >> psd_pkg::AVG_SHIFT)
                              + {{psd_pkg::AVG_SHIFT{1'b0}},
                                 i_cs_code[i*psd_pkg::CS_W +: psd_pkg::CS_W]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Writable registers

    // Host write strobes, one per writable command code
    // Sense, address and config codes have no strobe, so writes vanish
    logic        wr_rflt_lo;
    logic        wr_rflt_hi;
    logic        wr_skip;
    logic [15:0] rflt_lo_next;
    logic [3:0]  rflt_hi_next;

    // read-only codes decode to no write target
    assign wr_rflt_lo = i_req.wr && (i_req.cmd == psd_pkg::CMD_RFLT_LO);
    assign wr_rflt_hi = i_req.wr && (i_req.cmd == psd_pkg::CMD_RFLT_HI);
    assign wr_skip    = i_req.wr && (i_req.cmd == psd_pkg::CMD_SKIP_R1);

    // new fault flags OR into the stored word
    // A host write replaces the word, but a flag raised in the same
    // cycle is still kept: losing a fault report is the worse error
    assign rflt_lo_next = wr_rflt_lo ? (i_req.wdata | i_rfault_set[15:0])
                                     : (rflt_lo_reg | i_rfault_set[15:0]);

    // phases 17 to 20 live in bits 3:0 only
    // bits 15:4 have no storage, so writes to them are dropped
    assign rflt_hi_next = wr_rflt_hi
                        ? ((i_req.wdata[3:0] & psd_pkg::RFLT_HI_MSK[3:0])
                           | i_rfault_set[19:16])
                        : (rflt_hi_reg | i_rfault_set[19:16]);

    // Clearing a flag is a host write of zero to its bit; a fault that
    // is still present simply sets it again on the next report, so
    // software should read back after clearing to see what persists

    // Sticky fault flags and the host mask word
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rflt_lo_reg <= psd_pkg::RFLT_RST;
            rflt_hi_reg <= psd_pkg::RFLT_RST[3:0];
            skip_reg    <= psd_pkg::SKIP_RST;
        end else begin
            rflt_lo_reg <= rflt_lo_next;
            rflt_hi_reg <= rflt_hi_next;
            if (wr_skip) begin
                skip_reg <= i_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read selection

    // Map of readable words:
    //   channel 12 to 16 sense   five consecutive codes, read-only
    //   bus address              live pin level, read-only
    //   configuration index      live level, read-only
    //   fault flags low/high     sticky, host may overwrite
    //   rail-one skip mask       host word, applied at wrap

    // One hit per readable command code; at most one is high
    logic        hit_current_sense_input_twelve;
    logic        hit_cs13;
    logic        hit_cs14;
    logic        hit_cs15;
    logic        hit_cs16;
    logic        hit_addr;
    logic        hit_cfg;
    logic        hit_rflt_lo;
    logic        hit_rflt_hi;
    logic        hit_skip;

    // Word each code returns, already laid out in 16 bits
    logic [15:0] val_current_sense_input_twelve;
    logic [15:0] val_cs13;
    logic [15:0] val_cs14;
    logic [15:0] val_cs15;
    logic [15:0] val_cs16;
    logic [15:0] val_addr;
    logic [15:0] val_cfg;
    logic [15:0] val_rflt_hi;

    // Command code compares
    assign hit_current_sense_input_twelve    = (i_req.cmd == psd_pkg::CMD_CURRENT_SENSE_INPUT_TWELVE);
    assign hit_cs13    = (i_req.cmd == psd_pkg::CMD_CS13);
    assign hit_cs14    = (i_req.cmd == psd_pkg::CMD_CS14);
    assign hit_cs15    = (i_req.cmd == psd_pkg::CMD_CS15);
    assign hit_cs16    = (i_req.cmd == psd_pkg::CMD_CS16);
    assign hit_addr    = (i_req.cmd == psd_pkg::CMD_ADDR);
    assign hit_cfg     = (i_req.cmd == psd_pkg::CMD_CONFIG);
    assign hit_rflt_lo = (i_req.cmd == psd_pkg::CMD_RFLT_LO);
    assign hit_rflt_hi = (i_req.cmd == psd_pkg::CMD_RFLT_HI);
    assign hit_skip    = (i_req.cmd == psd_pkg::CMD_SKIP_R1);

    // ten-bit average code in bits 9:0
    // upper six bits padded with zero by zext_cs
    assign val_current_sense_input_twelve = zext_cs(avg_reg[0]);
    assign val_cs13 = zext_cs(avg_reg[1]);
    assign val_cs14 = zext_cs(avg_reg[2]);
    assign val_cs15 = zext_cs(avg_reg[3]);
    assign val_cs16 = zext_cs(avg_reg[4]);

    assign val_addr = {8'h00, i_bus_addr};

    assign val_cfg = {12'h000, i_config_num};

    assign val_rflt_hi = {12'h000, rflt_hi_reg};

    // Unmapped codes match no hit and read zero
    // An OR of masked words keeps the selector flat and easy to time
    assign rdata_next = ({16{hit_current_sense_input_twelve}}    & val_current_sense_input_twelve)
                      | ({16{hit_cs13}}    & val_cs13)
                      | ({16{hit_cs14}}    & val_cs14)
                      | ({16{hit_cs15}}    & val_cs15)
                      | ({16{hit_cs16}}    & val_cs16)
                      | ({16{hit_addr}}    & val_addr)
                      | ({16{hit_cfg}}     & val_cfg)
                      | ({16{hit_rflt_lo}} & rflt_lo_reg)
                      | ({16{hit_rflt_hi}} & val_rflt_hi)
                      | ({16{hit_skip}}    & skip_reg);

    // Answer register: valid pulses once per read, data holds between
    // reads so a slow host may pick it up late
    // A write never disturbs the held answer
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata  <= 16'h0000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            if (i_req.rd) begin
                o_rdata <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interleave engine

    // Last count of the period; the following edge starts a new cycle
    assign at_wrap = (cnt_reg == 16'(PERIOD - 1));

    // Switching period counter; wrap is the cycle boundary
    // PERIOD must fit in 16 bits and be at least the phase count,
    // or the slots collapse to zero and all phases start together
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= 16'h0000;
        end else if (at_wrap) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // mask latched only at period boundary
    // Avoids a truncated pulse on a phase being dropped
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            skip_live_reg <= psd_pkg::SKIP_RST;
        end else if (at_wrap) begin
            skip_live_reg <= skip_reg;
        end
    end

    // Live mask and the even spacing it implies
    // Every phase parked leaves nact at zero; slot then falls back to
    // the full period, which keeps the divide defined
    assign mask_live = skip_live_reg[NPH-1:0];
    assign nact      = 5'(NPH - $countones(mask_live));
    assign slot      = (nact == 5'h00) ? 16'(PERIOD) : 16'(PERIOD / nact);

    // active phases take even slots in rank order
    // bit 0 is phase 1
    // Ranks are counted in phase order, so the lowest active phase leads
    // Parked phases keep pwm low as well as released, so a weak
    // keeper on the pin never sees a stale high
    // Ticks mark slot starts only; the modulator owns pulse widths
    always_comb begin
        logic [4:0] rank;
        rank = 5'h00;
        for (int p = 0; p < NPH; p++) begin
            o_phase_tick[p] = 1'b0;
            o_pwm_oe[p]     = !mask_live[p];
            o_pwm[p]        = mask_live[p] ? 1'b0 : i_pwm_raw[p];
            if (!mask_live[p]) begin
                o_phase_tick[p] = (cnt_reg == 16'(32'(rank) * 32'(slot)));
                rank = rank + 5'h01;
            end
        end
    end

endmodule : psd_regs

/* File: psd_regs_sva.sv */
`timescale 1ns/1ns
module psd_regs_sva #(
    parameter int NPH    = psd_pkg::NPH,
    parameter int PERIOD = 100
) (
    input wire logic              i_clk,
    input wire logic              i_rst_b,
    input wire psd_pkg::psd_req_s i_req,
    input wire logic [15:0]       o_rdata,
    input wire logic              o_rvalid,
    input wire logic [7:0]        i_bus_addr,
    input wire logic [3:0]        i_config_num,
    input wire logic [NPH-1:0]    i_pwm_raw,
    input wire logic [NPH-1:0]    o_pwm,
    input wire logic [NPH-1:0]    o_pwm_oe,
    input wire logic [NPH-1:0]    o_phase_tick
);
    // Single domain, so clock and reset are given once
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    rd_answer_a: assert property (i_req.rd |=> o_rvalid) else $error("read unanswered");
    no_spur_a: assert property (!i_req.rd |=> !o_rvalid) else $error("stray rvalid");
    data_hold_a: assert property (!o_rvalid |-> $stable(o_rdata)) else $error("rdata moved");
    cs_upper_a: assert property (o_rvalid && $past(i_req.cmd) inside {[8'hDB:8'hDF]}
        |-> o_rdata[15:10] == 6'h00) else $error("sense upper bits set");
    addr_rd_a: assert property (i_req.rd && i_req.cmd == 8'hE4
        |=> o_rdata == {8'h00, $past(i_bus_addr)}) else $error("address readback wrong");
    cfg_rd_a: assert property (i_req.rd && i_req.cmd == 8'hE5
        |=> o_rdata == {12'h000, $past(i_config_num)}) else $error("config readback wrong");
    flt_hi_a: assert property (i_req.rd && i_req.cmd == 8'hE8
        |=> o_rdata[15:4] == 12'h000) else $error("fault high upper bits set");
    hiz_pwm_a: assert property ((o_pwm & ~o_pwm_oe) == '0) else $error("off phase drives");
    mask_edge_a: assert property (!$stable(o_pwm_oe) && o_pwm_oe != '0
        |-> o_phase_tick != '0) else $error("mask applied mid period");
    pass_pwm_a: assert property (((o_pwm ^ i_pwm_raw) & o_pwm_oe) == '0)
        else $error("active phase pwm differs");
    tick_act_a: assert property ((o_phase_tick & ~o_pwm_oe) == '0) else $error("off phase ticks");
endmodule : psd_regs_sva
bind psd_regs psd_regs_sva #(.NPH(NPH), .PERIOD(PERIOD)) i_psd_regs_sva (.*);

/* File: psd_regs_tb.sv */
`timescale 1ns/1ns
module psd_regs_tb;
    localparam int PER = 64;
    logic              clk, rst_b, csv, rvalid;
    logic [49:0]       code;
    logic [7:0]        addr;
    logic [3:0]        cfg;
    logic [19:0]       fset, fv;
    logic [15:0]       raw, rdata, q, mask, pwm, oe, tick;
    psd_pkg::psd_req_s req;
    int                n_fail, num_checks, seed, i, k;
    psd_regs #(.PERIOD(PER)) i_psd_regs (.i_clk(clk), .i_rst_b(rst_b), .i_req(req),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_cs_valid(csv), .i_cs_code(code), .i_bus_addr(addr),
        .i_config_num(cfg), .i_rfault_set(fset), .i_pwm_raw(raw), .o_pwm(pwm),
        .o_pwm_oe(oe), .o_phase_tick(tick));
    psd_host i_psd_host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        i_psd_host.xfer(1'b0, c, 16'h0000, q);
        check(q, exp);
        check({15'h0000, rvalid}, 16'h0001);
    endtask : rd
    // Converged filter output equals the steady input code
    function automatic logic [15:0] cs_exp(input int ch);
        return {6'h00, code[ch*10 +: 10]};
    endfunction : cs_exp
    task automatic conclude;
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Run is about a thousand cycles; this cuts a hang
    initial begin
        #600000;
        n_fail++;
        conclude;
    end
    initial begin
        seed = 32'h9C4C;
        rst_b = 1'b0;
        csv = 1'b0;
        fset = '0;
        code = 50'({$random(seed), $random(seed)});
        code[9:0] = 10'h3FF;
        raw = $random(seed);
        addr = $random(seed);
        cfg = 4'hF;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        rd(8'hE9, 16'h0000);
        for (i = 0; i < 3; i++) begin
            rd(8'hE4, {8'h00, addr});
            rd(8'hE5, {12'h000, cfg});
            addr = $random(seed);
            cfg = $random(seed);
        end
        $display("test readback ids done");
        // Step input held long enough for the average to settle
        repeat (200) begin
            @(negedge clk) csv = 1'b1;
            @(negedge clk) csv = 1'b0;
        end
        for (k = 0; k < 5; k++) rd(8'hDB + 8'(k), cs_exp(k));
        i_psd_host.xfer(1'b1, 8'hDC, 16'hFFFF, q);
        rd(8'hDC, cs_exp(1));
        $display("test sense readback done");
        fv = 20'($random(seed));
        @(negedge clk) fset = fv;
        @(negedge clk) fset = '0;
        rd(8'hE7, fv[15:0]);
        rd(8'hE8, {12'h000, fv[19:16]});
        i_psd_host.xfer(1'b1, 8'hE8, 16'hFFF5, q);
        rd(8'hE8, 16'h0005);
        i_psd_host.xfer(1'b1, 8'hE7, 16'h0000, q);
        rd(8'hE7, 16'h0000);
        $display("test faults done");
        for (i = 0; i < 3; i++) begin
            mask = (i == 0) ? 16'h000F : (i == 1) ? 16'($random(seed)) : 16'h0000;
            i_psd_host.xfer(1'b1, 8'hE9, mask, q);
            rd(8'hE9, mask);
            repeat (2 * PER) @(negedge clk);
            raw = $random(seed);
            #1 check(oe, ~mask);
            check(pwm, raw & ~mask);
            k = 0;
            repeat (PER) begin
                @(negedge clk);
                k += $countones(tick);
            end
            check(16'(k), 16'($countones(~mask)));
        end
        $display("test skip mask done");
        conclude;
    end
endmodule : psd_regs_tb
